//--- pmo_phase_offset.sv
// pmo_phase_offset.sv: inch and trapezoidal move offsets for a slave
// axis phase loop, with a classic wishbone register slave
// assumes loopActive comes from logic on the same clock
`timescale 1ns/1ps
`include "pmo_consts.svh"

module pmo_phase_offset #(
  parameter int TICK_CYCLES = `PMO_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // position loop side
  input wire logic loopActive,
  output pmo_pkg::pmo_offsets_type offsets,
  output pmo_pkg::pmo_flags_type flags
);
  import pmo_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] wbMerge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // signed clamp into a documented range
  function automatic logic [31:0] clampS(
    input logic [31:0] v,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    logic [31:0] res;
    res = v;
    if ($signed(v) < $signed(lo)) begin
      res = lo;
    end else if ($signed(v) > $signed(hi)) begin
      res = hi;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------

  logic wbReq;
  logic wbWr;
  logic [31:0] rdNxt;

  // a write lands on the edge at which the master sees ack
  assign wbReq = wb_cyc_i & wb_stb_i;
  assign wbWr = wbReq & wb_we_i & wb_ack_o;

  // write hit decode, shared by every register
  function automatic logic hit(input logic [7:0] ofs);
    return wbWr && (wb_adr_i == ofs);
  endfunction

  // one wait state: ack rises the cycle after the request, then drops
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq & ~wb_ack_o;
    end
  end

  // read data captured as ack rises and held while it stands
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (wbReq && !wb_ack_o) begin
      wb_dat_o <= rdNxt;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------

  pmo_ctrl_type ctrl_r;
  logic [31:0] inchRate_r;
  logic [31:0] inchGain_r;
  logic [31:0] distCrs_r;
  logic [31:0] distFine_r;
  logic [31:0] moveVel_r;
  logic [31:0] moveAcc_r;

  // command bits live in the low byte only
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= '0;
    end else if (hit(`PMO_CTRL_OFS) && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[5:0];
    end
  end

  // out-of-range writes clamp rather than fault, keeping steps sane
  always_ff @(posedge clk) begin
    if (rst) begin
      inchRate_r <= `PMO_RATE_RST;
      inchGain_r <= `PMO_GAIN_RST;
      distCrs_r <= `PMO_CRS_RST;
      distFine_r <= '0;
      moveVel_r <= `PMO_VEL_RST;
      moveAcc_r <= `PMO_ACC_RST;
    end else if (hit(`PMO_RATE_OFS)) begin
      inchRate_r <= clampS(wbMerge(inchRate_r, wb_dat_i, wb_sel_i),
        `PMO_RATE_MIN, `PMO_RATE_MAX);
    end else if (hit(`PMO_GAIN_OFS)) begin
      inchGain_r <= clampS(wbMerge(inchGain_r, wb_dat_i, wb_sel_i),
        `PMO_GAIN_MIN, `PMO_GAIN_MAX);
    end else if (hit(`PMO_CRS_OFS)) begin
      distCrs_r <= clampS(wbMerge(distCrs_r, wb_dat_i, wb_sel_i),
        `PMO_CRS_MIN, `PMO_CRS_MAX);
    end else if (hit(`PMO_FINE_OFS)) begin
      distFine_r <= clampS(wbMerge(distFine_r, wb_dat_i, wb_sel_i),
        `PMO_FINE_MIN, `PMO_FINE_MAX);
    end else if (hit(`PMO_VEL_OFS)) begin
      moveVel_r <= clampS(wbMerge(moveVel_r, wb_dat_i, wb_sel_i),
        `PMO_VEL_MIN, `PMO_VEL_MAX);
    end else if (hit(`PMO_ACC_OFS)) begin
      moveAcc_r <= clampS(wbMerge(moveAcc_r, wb_dat_i, wb_sel_i),
        `PMO_ACC_MIN, `PMO_ACC_MAX);
    end
  end

  // ---------------------------------------------------------------
  // control-sample tick
  // ---------------------------------------------------------------

  logic [31:0] tickCnt_r;
  logic tick_r;

  // one-cycle pulse every TICK_CYCLES clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
      tickCnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // inch offset
  // ---------------------------------------------------------------

  logic signed [47:0] inchOfs_r;
  logic [63:0] inchProd;
  logic [47:0] inchStep;
  logic inchUp;
  logic inchDown;

  // step per tick = rate * gain scaled to 2^-32 rev
  assign inchProd = 64'(inchRate_r) * 64'(inchGain_r)
    * 64'(`PMO_INCH_K);
  assign inchStep = inchProd[63:16];
  assign inchUp = ctrl_r.inchFwd & ~ctrl_r.inchBack;
  assign inchDown = ctrl_r.inchBack & ~ctrl_r.inchFwd;

  // offset persists; clear is refused while the loop runs
  always_ff @(posedge clk) begin
    if (rst) begin
      inchOfs_r <= '0;
    end else if (ctrl_r.inchClear && !loopActive) begin
      inchOfs_r <= '0;
    end else if (tick_r && inchUp) begin
      inchOfs_r <= inchOfs_r + $signed(inchStep);
    end else if (tick_r && inchDown) begin
      inchOfs_r <= inchOfs_r - $signed(inchStep);
    end
  end

  // ---------------------------------------------------------------
  // move trigger and profile
  // ---------------------------------------------------------------

  pmo_move_state_type state_r;
  logic enPrev_r;
  logic [63:0] remMag_r;
  logic [63:0] vel_r;
  logic moveNeg_r;
  logic signed [47:0] moveOfs_r;
  logic trig;
  logic signed [63:0] distS;
  logic [63:0] distMag;
  logic [63:0] accStep;
  logic [63:0] velMax;
  logic [63:0] velUp;
  logic [63:0] velNxt;
  logic [63:0] step;
  logic brake;
  logic stepNow;

  // rising edge of the enable bit
  always_ff @(posedge clk) begin
    if (rst) begin
      enPrev_r <= 1'b0;
    end else begin
      enPrev_r <= ctrl_r.moveEnable;
    end
  end
  assign trig = ctrl_r.moveEnable & ~enPrev_r;

  // distance in 2^-32 rev, split into sign and magnitude
  assign distS = $signed({{32{distCrs_r[31]}}, distCrs_r})
    * $signed(64'(`PMO_CRS_K))
    + $signed({{32{distFine_r[31]}}, distFine_r})
    * $signed(64'(`PMO_FINE_K));
  assign distMag = distS[63] ? 64'(-distS) : 64'(distS);

  // per-tick velocity limit and velocity change
  assign velMax = 64'(moveVel_r) * 64'(`PMO_VEL_K);
  assign accStep = (64'(moveAcc_r) * 64'(`PMO_ACC_K)) >> 10;
  assign velUp = vel_r + accStep;

  // brake once the stopping distance reaches what is left;
  // widths fit 64 bits because the ranges above are clamped
  assign brake = (vel_r * vel_r) >= ((accStep * remMag_r) << 1);

  // next feed rate: trapezoid with a floor so the tail completes
  always_comb begin
    velNxt = velUp;
    if (brake) begin
      velNxt = (vel_r > accStep) ? vel_r - accStep : accStep;
    end else if (vel_r > velMax) begin
      velNxt = (vel_r - accStep > velMax) ? vel_r - accStep : velMax;
    end else if (velUp > velMax) begin
      velNxt = velMax;
    end
  end

  // last step is trimmed so exactly the distance is fed
  assign step = (velNxt > remMag_r) ? remMag_r : velNxt;
  assign stepNow = (state_r == MV_RUN) && !ctrl_r.moveHold
    && !ctrl_r.moveAbort && tick_r;

  // sequencer: abort wins, triggers only land when no move runs
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= MV_IDLE;
      remMag_r <= '0;
      vel_r <= '0;
      moveNeg_r <= 1'b0;
    end else if (ctrl_r.moveAbort) begin
      state_r <= MV_IDLE;
      remMag_r <= '0;
      vel_r <= '0;
    end else if (trig && state_r != MV_RUN) begin
      remMag_r <= distMag;
      moveNeg_r <= distS[63];
      vel_r <= '0;
      if (distMag == 64'h0) begin
        state_r <= MV_IDLE;
      end else if (ctrl_r.moveHold) begin
        state_r <= MV_HELD;
      end else begin
        state_r <= MV_RUN;
      end
    end else begin
      case (state_r)
        MV_IDLE: begin
          state_r <= MV_IDLE;
        end
        MV_RUN: begin
          if (ctrl_r.moveHold) begin
            state_r <= MV_HELD;
          end else if (stepNow) begin
            remMag_r <= remMag_r - step;
            if (remMag_r == step) begin
              vel_r <= '0;
              state_r <= MV_IDLE;
            end else begin
              vel_r <= velNxt;
            end
          end
        end
        MV_HELD: begin
          if (!ctrl_r.moveHold) begin
            state_r <= MV_RUN;
          end
        end
        default: begin
          state_r <= MV_IDLE;
        end
      endcase
    end
  end
  // a trigger in MV_RUN falls through and is dropped

  // total offset of all moves; cleared only by abort with loop idle
  always_ff @(posedge clk) begin
    if (rst) begin
      moveOfs_r <= '0;
    end else if (ctrl_r.moveAbort && !loopActive) begin
      moveOfs_r <= '0;
    end else if (stepNow) begin
      if (moveNeg_r) begin
        moveOfs_r <= moveOfs_r - $signed(step[47:0]);
      end else begin
        moveOfs_r <= moveOfs_r + $signed(step[47:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs and read back
  // ---------------------------------------------------------------

  logic signed [47:0] distLeft;
  pmo_flags_type flags_r;

  assign distLeft = moveNeg_r ? -$signed(remMag_r[47:0])
    : $signed(remMag_r[47:0]);

  // flags registered, one cycle behind the state they show
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r.inchActive <= inchUp | inchDown;
      flags_r.moveActive <= (remMag_r != 64'h0);
      flags_r.moveHeld <= (state_r == MV_HELD);
    end
  end

  // both offsets in one Q16.32 format for direct summing
  assign offsets = '{inch: inchOfs_r, move: moveOfs_r};
  assign flags = flags_r;

  // read mux; unmapped addresses read zero and still get ack
  always_comb begin
    rdNxt = '0;
    if (wb_adr_i == `PMO_CTRL_OFS) begin
      rdNxt = {26'h0, ctrl_r};
    end else if (wb_adr_i == `PMO_RATE_OFS) begin
      rdNxt = inchRate_r;
    end else if (wb_adr_i == `PMO_GAIN_OFS) begin
      rdNxt = inchGain_r;
    end else if (wb_adr_i == `PMO_CRS_OFS) begin
      rdNxt = distCrs_r;
    end else if (wb_adr_i == `PMO_FINE_OFS) begin
      rdNxt = distFine_r;
    end else if (wb_adr_i == `PMO_VEL_OFS) begin
      rdNxt = moveVel_r;
    end else if (wb_adr_i == `PMO_ACC_OFS) begin
      rdNxt = moveAcc_r;
    end else if (wb_adr_i == `PMO_STAT_OFS) begin
      rdNxt = {29'h0, flags_r};
    end else if (wb_adr_i == `PMO_INCH_OFS) begin
      rdNxt = inchOfs_r[47:16];
    end else if (wb_adr_i == `PMO_MOVE_OFS) begin
      rdNxt = moveOfs_r[47:16];
    end else if (wb_adr_i == `PMO_LEFT_OFS) begin
      rdNxt = distLeft[47:16];
    end
  end

endmodule // pmo_phase_offset

//--- pmo_consts.svh
// pmo_consts.svh: offsets, scale factors and reset values of the phase offset
// block; assumes a 100 MHz clock and a 32-bit classic wishbone slave
`ifndef PMO_CONSTS_SVH
`define PMO_CONSTS_SVH
// How it works
// - inch-forward held: inch offset grows by the effective rate each tick
// - inch-backward held: inch offset shrinks by the effective rate each tick
// - both inch commands held: offset is left alone
// - inch clear zeroes the inch offset only while the loop is idle
// - inch rate in 0.0001 rev/s steps, 0.0001 to 30.0000, reset 0.1000
// - effective rate is rate times gain; gain 0.001 to 30.000, reset 1.000
// - inch offset readable, 2^-16 rev per unit, kept after inching stops
// - inch active flag set exactly while one inch command applies
// - move enable rising edge starts a move only when none is running
// - a new move request is ignored until the running move is done
// - hold freezes the move; a trigger while held replaces it
// - move abort stops the move and, with the loop idle, zeroes offset
// - distance is coarse (+-3000.0 rev) plus fine trim (+-1.0000 rev)
// - feed rate held to the velocity limit, or ramped down to it if lowered mid-move, 0.10 to 300.00 percent
// - feed rate changes no faster than acceleration, 0.01 to 300.00 pct
// - move active flag set while distance left is nonzero
// - distance left is readable
// - total move offset readable, 2^-16 rev per unit
// - trapezoid: ramp up, cruise, ramp down, adding exactly the distance

// control-sample tick
`define PMO_CLK_NS 10
`define PMO_TICK_NS 1000000
`define PMO_TICK_CYC (`PMO_TICK_NS / `PMO_CLK_NS)

// register byte offsets
`define PMO_CTRL_OFS 8'h00
`define PMO_RATE_OFS 8'h04
`define PMO_GAIN_OFS 8'h08
`define PMO_CRS_OFS 8'h0C
`define PMO_FINE_OFS 8'h10
`define PMO_VEL_OFS 8'h14
`define PMO_ACC_OFS 8'h18
`define PMO_STAT_OFS 8'h1C
`define PMO_INCH_OFS 8'h20
`define PMO_MOVE_OFS 8'h24
`define PMO_LEFT_OFS 8'h28

// ranges and reset values, scaled integers
`define PMO_RATE_MIN 32'h0000_0001
`define PMO_RATE_MAX 32'h0004_93E0
`define PMO_RATE_RST 32'h0000_03E8
`define PMO_GAIN_MIN 32'h0000_0001
`define PMO_GAIN_MAX 32'h0000_7530
`define PMO_GAIN_RST 32'h0000_03E8
`define PMO_CRS_MIN 32'hFFFF_8AD0
`define PMO_CRS_MAX 32'h0000_7530
`define PMO_CRS_RST 32'h0000_000A
`define PMO_FINE_MIN 32'hFFFF_D8F0
`define PMO_FINE_MAX 32'h0000_2710
`define PMO_VEL_MIN 32'h0000_000A
`define PMO_VEL_MAX 32'h0000_7530
`define PMO_VEL_RST 32'h0000_0064
`define PMO_ACC_MIN 32'h0000_0001
`define PMO_ACC_MAX 32'h0000_7530
`define PMO_ACC_RST 32'h0000_0064

// scale factors into 2^-32 rev per tick (max load speed 10 rev/s)
`define PMO_INCH_K 32'h0000_6DF3
`define PMO_VEL_K 32'h0000_10C7
`define PMO_ACC_K 32'h0000_112E
`define PMO_CRS_K 32'h1999_999A
`define PMO_FINE_K 32'h0006_8DB9
`endif

//--- pmo_pkg.sv
// pmo_pkg.sv: types shared by the phase offset block and its users
// assumes nothing beyond a SystemVerilog compiler
package pmo_pkg;
  // move sequencer states
  typedef enum logic [2:0] {
    MV_IDLE = 3'b001,
    MV_RUN = 3'b010,
    MV_HELD = 3'b100
  } pmo_move_state_type;
  // offsets to the loop, 1.0 rev = 2^32
  typedef struct packed {
    logic signed [47:0] inch;
    logic signed [47:0] move;
  } pmo_offsets_type;
  // status flags to the loop
  typedef struct packed {
    logic moveHeld;
    logic moveActive;
    logic inchActive;
  } pmo_flags_type;
  // control register layout, inchFwd in bit 0
  typedef struct packed {
    logic moveAbort;
    logic moveHold;
    logic moveEnable;
    logic inchClear;
    logic inchBack;
    logic inchFwd;
  } pmo_ctrl_type;
endpackage

//--- pmo_phase_offset_checker.sv
// pmo_phase_offset_checker.sv: port assertions for the phase offset block
// assumes it is bound to pmo_phase_offset and sees one clock domain
`timescale 1ns/1ps
module pmo_phase_offset_checker #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // loop side
  input wire pmo_pkg::pmo_offsets_type offsets,
  input wire pmo_pkg::pmo_flags_type flags
);
  import pmo_pkg::*;
  // ----------------
  // step history
  // ----------------
  // worst-case caps: 300 pct velocity and 300 pct acceleration per tick
  localparam int VelCap = 128850000;
  localparam int AccCap = 128847;
  logic signed [47:0] prevInch_r, prevMove_r, lastAbs_r, dMv, aMv;
  logic [31:0] gap_r;
  logic stepMv, stepNow;
  // zeroing by clear or abort is not a step, so it is left out
  assign dMv = offsets.move - prevMove_r;
  assign aMv = dMv < 0 ? -dMv : dMv;
  assign stepMv = dMv != 0 && offsets.move != 0;
  assign stepNow = stepMv || (offsets.inch != prevInch_r && offsets.inch != 0);
  // gap starts saturated so the first tick after reset is legal
  always_ff @(posedge clk) begin
    prevInch_r <= offsets.inch;
    prevMove_r <= offsets.move;
    if (rst) begin
      gap_r <= TICK_CYCLES;
      lastAbs_r <= '0;
    end else begin
      if (stepNow) begin
        gap_r <= '0;
      end else if (gap_r < TICK_CYCLES) begin
        gap_r <= gap_r + 1;
      end
      if (stepMv) begin
        lastAbs_r <= aMv;
      end
    end
  end
  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("no ack one cycle after request");
  read_inch_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i &&
    !wb_ack_o && wb_adr_i == 8'h20 |=> wb_dat_o == $past(offsets.inch[47:16]))
    else $error("inch offset read mismatch");
  inch_idle_a: assert property (!flags.inchActive &&
    !$past(flags.inchActive) |-> $stable(offsets.inch) || offsets.inch == 0)
    else $error("inch offset moved while inactive");
  move_idle_a: assert property (!flags.moveActive &&
    !$past(flags.moveActive) |-> $stable(offsets.move) || offsets.move == 0)
    else $error("move offset moved while inactive");
  held_frozen_a: assert property (flags.moveHeld &&
    $past(flags.moveHeld) |-> $stable(offsets.move) || offsets.move == 0)
    else $error("move offset moved while held");
  tick_gap_a: assert property (stepNow |-> gap_r >= TICK_CYCLES - 1)
    else $error("offset steps closer than a tick");
  vel_cap_a: assert property (stepMv |-> aMv <= VelCap)
    else $error("move step above velocity cap");
  acc_cap_a: assert property (stepMv |-> aMv <= lastAbs_r + AccCap)
    else $error("move step grew faster than acceleration");
endmodule // pmo_phase_offset_checker

bind pmo_phase_offset pmo_phase_offset_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) i_pmo_phase_offset_checker (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .offsets(offsets), .flags(flags)
);

//--- pmo_loop_model.sv
// pmo_loop_model.sv: behavioural position loop error calculator
// assumes the bench says when the loop runs; same clock as the block
`timescale 1ns/1ps
module pmo_loop_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic runLoop,
  input wire logic clrMax,
  // block side
  input wire pmo_pkg::pmo_offsets_type offsets,
  output logic loopActive,
  output logic signed [47:0] posDemand,
  output logic signed [47:0] inchStep,
  output logic signed [47:0] moveMax
);
  import pmo_pkg::*;
  logic signed [47:0] prevInch_r, prevMove_r, dMove, aMove;
  // one format for both, so they sum raw
  assign posDemand = offsets.inch + offsets.move;
  assign dMove = offsets.move - prevMove_r;
  assign aMove = dMove < 0 ? -dMove : dMove;
  // loop state, registered, no synchroniser needed
  always_ff @(posedge clk) begin
    loopActive <= rst ? 1'b0 : runLoop;
  end
  // last inch step and largest move step; zeroing is not a step
  always_ff @(posedge clk) begin
    prevInch_r <= offsets.inch;
    prevMove_r <= offsets.move;
    if (rst) begin
      inchStep <= '0;
    end else if (offsets.inch != prevInch_r && offsets.inch != 0) begin
      inchStep <= offsets.inch - prevInch_r;
    end
    if (rst || clrMax) begin
      moveMax <= '0;
    end else if (offsets.move != 0 && aMove > moveMax) begin
      moveMax <= aMove;
    end
  end
endmodule // pmo_loop_model

//--- tb_top.sv
// tb_top.sv: self-checking bench for the phase offset block
// assumes the checker binds itself and a short tick period is legal
`timescale 1ns/1ps
`include "pmo_consts.svh"
module tb_top;
  import pmo_pkg::*;
  localparam int Tick = 10;
  logic clk, rst, wbCyc, wbStb, wbWe, wbAck, runLoop, clrMax, loopActive;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, rd;
  pmo_offsets_type offsets;
  pmo_flags_type flags;
  logic signed [47:0] inchStep, moveMax, posDemand;
  int bad_count, checks_done, cycles;
  pmo_phase_offset #(
    .TICK_CYCLES(Tick)
  ) i_pmo_phase_offset (
    .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .loopActive(loopActive),
    .offsets(offsets), .flags(flags)
  );
  pmo_loop_model i_pmo_loop_model (
    .clk(clk), .rst(rst), .runLoop(runLoop), .clrMax(clrMax),
    .offsets(offsets), .loopActive(loopActive), .posDemand(posDemand),
    .inchStep(inchStep), .moveMax(moveMax)
  );
  // ----------------
  // bus and check helpers
  // ----------------
  always #5 clk = ~clk;
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until ack is seen at an edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task wr2(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
    wb(1'b0, a, 32'h0);
  endtask
  task ctl(input logic [5:0] c);
    wb(1'b1, 8'h00, {26'h0, c});
  endtask
  task ticks(input int n);
    repeat (n * Tick) @(posedge clk);
  endtask
  // flags lag, so let the move start before polling
  task wait_idle;
    ticks(2);
    while (flags.moveActive !== 1'b0) @(posedge clk);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_regs;
    logic [7:0] a [8];
    logic [31:0] e [8];
    a = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40};
    e = '{32'h3E8, 32'h3E8, 32'hA, 32'h0, 32'h64, 32'h64, 32'h0, 32'h0};
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      chk(rd, e[i]);
    end
    wr2(8'h04, 32'h0);
    chk(rd, 32'h1);
    wr2(8'h08, 32'h0000_9C40);
    chk(rd, 32'h0000_7530);
    $display("regs done");
  endtask
  task t_inch;
    longint s;
    longint v;
    s = (longint'(1000) * 2000 * 28147) >>> 16;
    wb(1'b1, 8'h04, 32'h3E8);
    wb(1'b1, 8'h08, 32'h7D0);
    ctl(6'h02);
    ticks(2);
    chk(inchStep, -s);
    ctl(6'h01);
    ticks(4);
    chk(inchStep, s);
    chk(flags.inchActive, 1'b1);
    ctl(6'h03);
    ticks(1);
    v = offsets.inch;
    ticks(3);
    chk(offsets.inch, v);
    chk(flags.inchActive, 1'b0);
    chk(v != 0, 1'b1);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'(v >>> 16));
    runLoop <= 1'b1;
    ctl(6'h04);
    ticks(2);
    chk(offsets.inch, v);
    runLoop <= 1'b0;
    ticks(1);
    chk(offsets.inch, 0);
    ctl(6'h00);
    $display("inch done");
  endtask
  task t_move;
    longint d;
    d = longint'(`PMO_CRS_K) + 5 * longint'(`PMO_FINE_K);
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h10, 32'h5);
    wb(1'b1, 8'h14, 32'h0000_7530);
    wb(1'b1, 8'h18, 32'h0000_7530);
    ctl(6'h08);
    ticks(5);
    chk(flags.moveActive, 1'b1);
    wb(1'b0, 8'h28, 32'h0);
    chk(rd != 0, 1'b1);
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h2);
    ctl(6'h00);
    ctl(6'h08);
    wait_idle;
    chk(offsets.move, d);
    chk(posDemand, d);
    wr2(8'h28, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'(d >>> 16));
    ctl(6'h00);
    $display("move done");
  endtask
  task t_vel;
    longint b;
    clrMax <= 1'b1;
    wb(1'b1, 8'h0C, 32'h0);
    clrMax <= 1'b0;
    wb(1'b1, 8'h10, 32'hFFFF_FF38);
    wb(1'b1, 8'h14, 32'h64);
    b = offsets.move;
    ctl(6'h08);
    wait_idle;
    chk(offsets.move - b, -200 * longint'(`PMO_FINE_K));
    chk(moveMax <= 100 * longint'(`PMO_VEL_K), 1'b1);
    ctl(6'h00);
    $display("velocity done");
  endtask
  task t_hold;
    longint v;
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h14, 32'h0000_7530);
    ctl(6'h08);
    ticks(20);
    ctl(6'h18);
    ticks(1);
    v = offsets.move;
    ticks(3);
    chk(offsets.move, v);
    chk(flags.moveHeld, 1'b1);
    ctl(6'h10);
    ctl(6'h18);
    ticks(2);
    chk(offsets.move, v);
    ctl(6'h08);
    wait_idle;
    chk(offsets.move - v, longint'(`PMO_CRS_K));
    $display("hold done");
  endtask
  task t_abort;
    longint v;
    ctl(6'h00);
    ctl(6'h08);
    ticks(10);
    runLoop <= 1'b1;
    ctl(6'h20);
    ticks(1);
    v = offsets.move;
    ticks(3);
    chk(offsets.move, v);
    chk(flags.moveActive, 1'b0);
    ctl(6'h00);
    runLoop <= 1'b0;
    ctl(6'h20);
    ticks(1);
    chk(offsets.move, 0);
    ctl(6'h00);
    $display("abort done");
  endtask
  // ----------------
  // run control
  // ----------------
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 5200 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, runLoop, clrMax} = '0;
    wbAdr = 8'h0;
    wbDatI = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_inch;
    t_move;
    t_vel;
    t_hold;
    t_abort;
    finish_test;
  end
endmodule // tb_top
